// ### core/adc_link_pkg.sv
package adc_link_pkg;
	// ==========================================
	// Frame layout
	localparam int RESULT_BITS     = 14;
	localparam int LEAD_ZEROS      = 2;
	localparam int FRAME_BITS      = 16;
	localparam int CNT_W           = 5;
	// ==========================================
	// Timing, in ns, and cycle counts at the 50 MHz clock
	localparam int CLK_NS          = 20;
	localparam int CONV_NS         = 5000;
	localparam int WAKE_NS         = 5000;
	localparam int QUIET_NS        = 250;
	localparam int LONG_PULSE_NS   = 6000;
	localparam int SHORT_PULSE_NS  = 1000;
	localparam int CONV_CYC        = CONV_NS / CLK_NS;
	localparam int WAKE_CYC        = WAKE_NS / CLK_NS;
	localparam int QUIET_CYC       = (QUIET_NS + CLK_NS - 1) / CLK_NS;
	localparam int LONG_PULSE_CYC  = (LONG_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SHORT_PULSE_CYC = (SHORT_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W           = 12;
	// Host shift clock half period in system clocks
	localparam int SCLK_HALF_CYC   = 4;
	// ==========================================
	// Device states, Gray along idle->convert->sleep->wake
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CONV  = 2'b01,
		ST_SLEEP = 2'b11,
		ST_WAKE  = 2'b10
	} dev_state_t;
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_PULSE = 3'b001,
		H_WAIT  = 3'b011,
		H_READ  = 3'b010,
		H_QUIET = 3'b110
	} host_state_t;
endpackage

// ### core/adc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adc_link_if;
	logic conv_start_n;
	logic shift_clock;
	logic busy;
	logic shift_data_out;
	logic shift_data_oe_n;
	modport device (
		input  conv_start_n,
		input  shift_clock,
		output busy,
		output shift_data_out,
		output shift_data_oe_n
	);
	modport host (
		output conv_start_n,
		output shift_clock,
		input  busy,
		input  shift_data_out,
		input  shift_data_oe_n
	);
endinterface
`default_nettype wire

// ### core/adc_device.sv
// How it works
// - Start falling edge holds, converts, raises busy
// - High-rate busy falls by 5 us, loads result
// - Read is sixteen host shift clocks
// - Host ends read 250 ns before start
// - Start level at conversion end picks mode
// - Start rising edge wakes sleeping device, 5 us
// - Host start pulse short or over 6 us
// - Short pulse: wake plus convert about 10 us
// - Long pulse: convert ends 5 us after fall
// - Sleeping device still allows serial read
// - Bits change on shift clock falling edge
// - First zero driven on first rising edge
// - Two zeros then 14 bits, MSB first
// - LSB held through 16th fall, then three-state
// - Host parks shift clock low after read
// - Extra pulses restart shifting, output stays driven
// - Start fall resets counter if clock low, outside conversion
// - Host keeps shift clock low during conversion
// - Clock may pause; bit position kept
// - Busy-blind host reads 5 us after start
// - Track resumes when busy falls
// - Conversion timed by own clock, not link
`timescale 1ns/10ps
`default_nettype none
module adc_device #(
	parameter int CONV_CYC = adc_link_pkg::CONV_CYC,
	parameter int WAKE_CYC = adc_link_pkg::WAKE_CYC
) (
	// Clock and reset
	input  wire logic                     i_clk,
	input  wire logic                     i_rstn,
	// Link
	adc_link_if.device                    link,
	// Analog stand-in
	input  wire logic [adc_link_pkg::RESULT_BITS-1:0] i_sample,
	output logic                          o_holding,
	output logic                          o_asleep
);
	initial begin
		if (CONV_CYC < 2 || CONV_CYC >= (1 << adc_link_pkg::TMR_W) ||
		    WAKE_CYC < 2 || WAKE_CYC >= (1 << adc_link_pkg::TMR_W))
			$error("adc_device: cycle counts out of range");
	end

	localparam logic [adc_link_pkg::TMR_W-1:0] CONV_T =
		adc_link_pkg::TMR_W'(CONV_CYC - 1);
	localparam logic [adc_link_pkg::TMR_W-1:0] WAKE_T =
		adc_link_pkg::TMR_W'(WAKE_CYC - 1);
	localparam logic [adc_link_pkg::CNT_W-1:0] LAST_BIT =
		adc_link_pkg::CNT_W'(adc_link_pkg::FRAME_BITS);

	// ==========================================
	// Pin synchronisers
	logic [1:0] cs_sync_q;
	logic [1:0] sc_sync_q;
	logic       cs_prev_q;
	logic       sc_prev_q;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cs_sync_q <= 2'h3;
			sc_sync_q <= 2'h0;
			cs_prev_q <= 1'b1;
			sc_prev_q <= 1'b0;
		end else begin
			cs_sync_q <= {cs_sync_q[0], link.conv_start_n};
			sc_sync_q <= {sc_sync_q[0], link.shift_clock};
			cs_prev_q <= cs_sync_q[1];
			sc_prev_q <= sc_sync_q[1];
		end
	end
	wire cs_lvl  = cs_sync_q[1];
	wire sc_lvl  = sc_sync_q[1];
	wire cs_fall = cs_prev_q & ~cs_lvl;
	wire cs_rise = ~cs_prev_q & cs_lvl;
	wire sc_fall = sc_prev_q & ~sc_lvl;
	wire sc_rise = ~sc_prev_q & sc_lvl;

	// ==========================================
	// Conversion sequencer
	adc_link_pkg::dev_state_t state_q, state_d;
	logic [adc_link_pkg::TMR_W-1:0] tmr_q, tmr_d;
	logic        hold_q, hold_d;
	logic        load;
	logic        short_q;
	wire tmr_done = (tmr_q == '0);

	always_comb begin
		state_d = state_q;
		tmr_d   = tmr_done ? tmr_q : tmr_q - 1'b1;
		hold_d  = hold_q;
		load    = 1'b0;
		case (state_q)
			adc_link_pkg::ST_IDLE: begin
				if (cs_fall) begin
					state_d = adc_link_pkg::ST_CONV;
					tmr_d   = CONV_T;
					hold_d  = 1'b1;
				end
			end
			adc_link_pkg::ST_CONV: begin
				// Falls here are ignored
				if (tmr_done) begin
					load   = 1'b1;
					hold_d = 1'b0;
					state_d = cs_lvl ? adc_link_pkg::ST_IDLE
						: adc_link_pkg::ST_SLEEP;
				end
			end
			adc_link_pkg::ST_SLEEP: begin
				if (cs_rise) begin
					state_d = adc_link_pkg::ST_WAKE;
					tmr_d   = WAKE_T;
				end
			end
			adc_link_pkg::ST_WAKE: begin
				// Long pulse: the fall itself samples
				if (cs_fall && tmr_done) begin
					state_d = adc_link_pkg::ST_CONV;
					tmr_d   = CONV_T;
					hold_d  = 1'b1;
				end else if (tmr_done && short_q) begin
					// Short pulse: remembered fall, hold at wake end
					state_d = adc_link_pkg::ST_CONV;
					tmr_d   = CONV_T;
					hold_d  = 1'b1;
				end
			end
			default: state_d = adc_link_pkg::ST_IDLE;
		endcase
	end

	// Fall while waking marks a short pulse; start may rise again later
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= adc_link_pkg::ST_IDLE;
			tmr_q   <= '0;
			hold_q  <= 1'b0;
			short_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tmr_q   <= tmr_d;
			hold_q  <= hold_d;
			if (state_q == adc_link_pkg::ST_WAKE && cs_fall)
				short_q <= 1'b1;
			else if (state_q != adc_link_pkg::ST_WAKE)
				short_q <= 1'b0;
		end
	end
	// In short-pulse case the fall comes early: busy covers wake
	wire busy_w = (state_q == adc_link_pkg::ST_CONV) |
		(state_q == adc_link_pkg::ST_WAKE && (short_q || !cs_lvl));

	// ==========================================
	// Output register and serial shifter
	logic [adc_link_pkg::RESULT_BITS-1:0] result_q;
	logic [adc_link_pkg::FRAME_BITS-1:0]  shreg_q;
	logic [adc_link_pkg::CNT_W-1:0]       bitcnt_q;
	logic                                 dout_q;
	logic                                 oe_n_q;
	logic                                 wrap_q;
	wire [adc_link_pkg::FRAME_BITS-1:0] frame =
		{{adc_link_pkg::LEAD_ZEROS{1'b0}}, result_q};
	wire last_fall = sc_fall && (bitcnt_q == LAST_BIT);
	// Falls in a waking device still restart the frame
	wire reset_ser = cs_fall && !sc_lvl &&
		(state_q != adc_link_pkg::ST_CONV);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			result_q <= '0;
		else if (load)
			result_q <= i_sample;
	end

	// Works in every state, sleep included
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bitcnt_q <= '0;
			shreg_q  <= '0;
			dout_q   <= 1'b0;
			oe_n_q   <= 1'b1;
			wrap_q   <= 1'b0;
		end else if (reset_ser) begin
			bitcnt_q <= '0;
			shreg_q  <= '0;
			oe_n_q   <= 1'b1;
			wrap_q   <= 1'b0;
		end else if (sc_rise && bitcnt_q == '0) begin
			// First leading zero out on first rise
			shreg_q  <= frame;
			dout_q   <= frame[adc_link_pkg::FRAME_BITS-1];
			oe_n_q   <= 1'b0;
			bitcnt_q <= 5'h01;
		end else if (last_fall) begin
			// LSB valid through 16th fall, then release on first frame since start fall
			bitcnt_q <= '0;
			oe_n_q   <= ~wrap_q;
			wrap_q   <= 1'b1;
		end else if (sc_fall && bitcnt_q != '0) begin
			shreg_q  <= {shreg_q[adc_link_pkg::FRAME_BITS-2:0], 1'b0};
			dout_q   <= shreg_q[adc_link_pkg::FRAME_BITS-2];
			bitcnt_q <= bitcnt_q + 5'h01;
		end
	end

	assign link.busy            = busy_w;
	assign link.shift_data_out  = dout_q;
	assign link.shift_data_oe_n = oe_n_q;
	assign o_holding            = hold_q;
	assign o_asleep             = (state_q == adc_link_pkg::ST_SLEEP);
endmodule
`default_nettype wire

// ### core/adc_host.sv
`timescale 1ns/10ps
`default_nettype none
module adc_host #(
	parameter int  SCLK_HALF = adc_link_pkg::SCLK_HALF_CYC,
	parameter int  PULSE_CYC = adc_link_pkg::SHORT_PULSE_CYC
) (
	// Clock and reset
	input  wire logic                     i_clk,
	input  wire logic                     i_rstn,
	// Link
	adc_link_if.host                      link,
	// User side
	input  wire logic                     i_start,
	input  wire logic                     i_sleep_mode,
	output logic                          o_ready,
	output logic                          o_valid,
	output logic [adc_link_pkg::RESULT_BITS-1:0] o_result
);
	initial begin
		if (SCLK_HALF < 3 || PULSE_CYC < 2 || PULSE_CYC > 255)
			$error("adc_host: parameter out of range");
	end

	localparam logic [7:0] PULSE_T = 8'(PULSE_CYC - 1);
	localparam logic [7:0] HALF_T  = 8'(SCLK_HALF - 1);
	localparam logic [7:0] QUIET_T = 8'(adc_link_pkg::QUIET_CYC);

	// ==========================================
	// Busy and data synchronisers
	logic [1:0] busy_sync_q;
	logic [1:0] dat_sync_q;
	logic       busy_seen_q;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			busy_sync_q <= 2'h0;
			dat_sync_q  <= 2'h0;
		end else begin
			busy_sync_q <= {busy_sync_q[0], link.busy};
			dat_sync_q  <= {dat_sync_q[0], link.shift_data_out};
		end
	end

	// ==========================================
	// Sequencer
	adc_link_pkg::host_state_t state_q;
	logic [7:0]  tmr_q;
	logic [4:0]  edges_q;
	logic        cs_n_q;
	logic        sc_q;
	logic        mode_q;
	logic [adc_link_pkg::FRAME_BITS-1:0] sh_q;
	logic        valid_q;
	logic [adc_link_pkg::RESULT_BITS-1:0] res_q;
	wire tmr_done = (tmr_q == 8'h00);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q     <= adc_link_pkg::H_IDLE;
			tmr_q       <= 8'h00;
			edges_q     <= 5'h00;
			cs_n_q      <= 1'b1;
			sc_q        <= 1'b0;
			mode_q      <= 1'b0;
			sh_q        <= '0;
			busy_seen_q <= 1'b0;
			valid_q     <= 1'b0;
			res_q       <= '0;
		end else begin
			valid_q <= 1'b0;
			if (!tmr_done)
				tmr_q <= tmr_q - 8'h01;
			case (state_q)
				adc_link_pkg::H_IDLE: begin
					// Clock parked low between reads
					sc_q <= 1'b0;
					if (i_start) begin
						mode_q  <= i_sleep_mode;
						cs_n_q  <= 1'b0;
						tmr_q   <= PULSE_T;
						state_q <= adc_link_pkg::H_PULSE;
					end
				end
				adc_link_pkg::H_PULSE: begin
					if (tmr_done) begin
						// Sleep mode keeps start low past conversion
						cs_n_q      <= ~mode_q;
						busy_seen_q <= 1'b0;
						state_q     <= adc_link_pkg::H_WAIT;
					end
				end
				adc_link_pkg::H_WAIT: begin
					// Read only after busy falls
					if (busy_sync_q[1])
						busy_seen_q <= 1'b1;
					else if (busy_seen_q) begin
						cs_n_q  <= 1'b1;
						edges_q <= 5'h00;
						tmr_q   <= HALF_T;
						state_q <= adc_link_pkg::H_READ;
					end
				end
				adc_link_pkg::H_READ: begin
					// Sixteen full clocks, sample on falls
					if (tmr_done) begin
						tmr_q <= HALF_T;
						sc_q  <= ~sc_q;
						if (sc_q) begin
							sh_q    <= {sh_q[adc_link_pkg::FRAME_BITS-2:0],
								dat_sync_q[1]};
							edges_q <= edges_q + 5'h01;
							if (edges_q == 5'h0f) begin
								tmr_q   <= QUIET_T;
								state_q <= adc_link_pkg::H_QUIET;
							end
						end
					end
				end
				adc_link_pkg::H_QUIET: begin
					if (tmr_done) begin
						valid_q <= 1'b1;
						res_q   <= sh_q[adc_link_pkg::RESULT_BITS-1:0];
						state_q <= adc_link_pkg::H_IDLE;
					end
				end
				default: state_q <= adc_link_pkg::H_IDLE;
			endcase
		end
	end

	assign link.conv_start_n = cs_n_q;
	assign link.shift_clock  = sc_q;
	assign o_ready  = (state_q == adc_link_pkg::H_IDLE);
	assign o_valid  = valid_q;
	assign o_result = res_q;
endmodule
`default_nettype wire

// ### sim/adc_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module adc_link_assertions #(
	parameter int CONV_CYC  = adc_link_pkg::CONV_CYC,
	parameter int WAKE_CYC  = adc_link_pkg::WAKE_CYC,
	parameter int QUIET_CYC = adc_link_pkg::QUIET_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Link
	input wire logic conv_start_n,
	input wire logic shift_clock,
	input wire logic busy,
	input wire logic shift_data_out,
	input wire logic shift_data_oe_n
);
	// ==========================================
	// Helper counters
	logic [9:0] bcnt_q;
	logic [7:0] qcnt_q;
	wire  [9:0] bcnt_d;
	wire  [7:0] qcnt_d;
	// Quiet count saturates so a start right after reset is legal
	assign bcnt_d = busy ? bcnt_q + 10'h001 : 10'h000;
	assign qcnt_d = shift_clock ? 8'h00 :
		((qcnt_q == 8'hff) ? qcnt_q : qcnt_q + 8'h01);
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bcnt_q <= 10'h000;
			qcnt_q <= 8'hff;
		end else begin
			bcnt_q <= bcnt_d;
			qcnt_q <= qcnt_d;
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	AST_BUSY_RISE: assert property (
		$fell(conv_start_n) && !busy |-> ##[1:8] busy)
		else $error("busy did not follow start fall");
	AST_BUSY_MIN: assert property (
		$fell(busy) |-> bcnt_q >= CONV_CYC - 2)
		else $error("conversion too short");
	AST_BUSY_MAX: assert property (
		bcnt_q <= CONV_CYC + WAKE_CYC + 8)
		else $error("busy held too long");
	AST_QUIET: assert property (
		$fell(conv_start_n) |-> qcnt_q >= QUIET_CYC - 1)
		else $error("start too soon after read");
	AST_SCLK_LOW_BUSY: assert property (
		busy |-> !shift_clock)
		else $error("shift clock moved during conversion");
	AST_NO_DRIVE_BUSY: assert property (
		busy |-> shift_data_oe_n)
		else $error("data driven during conversion");
	AST_DATA_HOLD: assert property (
		shift_clock && $past(shift_clock) && !shift_data_oe_n &&
		!$past(shift_data_oe_n) |-> $stable(shift_data_out))
		else $error("data changed while shift clock high");
	AST_LEAD_ZERO: assert property (
		$fell(shift_data_oe_n) |-> shift_clock && !shift_data_out)
		else $error("first bit not a zero on the rise");
	AST_RELEASE_LOW: assert property (
		$rose(shift_data_oe_n) |-> !shift_clock)
		else $error("data released with shift clock high");
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// ==========================================
	// Stimulus and design
	localparam int CONV = adc_link_pkg::CONV_CYC;
	localparam int WAKE = adc_link_pkg::WAKE_CYC;
	logic        i_clk        = 1'b0;
	logic        i_rstn       = 1'b0;
	logic        i_start      = 1'b0;
	logic        i_sleep_mode = 1'b0;
	logic [13:0] i_sample     = 14'h0000;
	logic        o_ready;
	logic        o_valid;
	logic        o_holding;
	logic        o_asleep;
	logic [13:0] o_result;
	logic [15:0] frame_q      = 16'h0000;
	logic [13:0] pat [4]      = '{14'h3fff, 14'h0000, 14'h2aaa, 14'h1555};
	int          n_mismatch   = 0;
	int          tests_run    = 0;
	always #10 i_clk = ~i_clk;
	adc_link_if link ();
	// Released line floats as a host would see it
	wire         shift_data_out_pin;
	assign shift_data_out_pin = link.shift_data_oe_n ? 1'bz : link.shift_data_out;
	adc_device i_adc_device (.i_clk(i_clk), .i_rstn(i_rstn), .link(link),
		.i_sample(i_sample), .o_holding(o_holding), .o_asleep(o_asleep));
	adc_host i_adc_host (.i_clk(i_clk), .i_rstn(i_rstn), .link(link),
		.i_start(i_start), .i_sleep_mode(i_sleep_mode), .o_ready(o_ready),
		.o_valid(o_valid), .o_result(o_result));
	adc_link_assertions i_adc_link_assertions (.i_clk(i_clk),
		.i_rstn(i_rstn), .conv_start_n(link.conv_start_n),
		.shift_clock(link.shift_clock), .busy(link.busy),
		.shift_data_out(link.shift_data_out),
		.shift_data_oe_n(link.shift_data_oe_n));
	// Wire level as a host would take it on each falling edge
	always @(negedge link.shift_clock) begin
		frame_q <= {frame_q[14:0], shift_data_out_pin};
	end
	// ==========================================
	// Tasks
	task chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task results();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task step();
		@(posedge i_clk);
		#1;
	endtask
	task convert(input logic sleep, input logic [13:0] smp);
		int   n;
		logic h;
		n = 0;
		h = 1'b0;
		i_sample = smp;
		i_sleep_mode = sleep;
		while (!o_ready && n < 2000) begin
			step();
			n++;
		end
		chk("ready", 16'h0001, {15'h0000, o_ready});
		i_start = 1'b1;
		step();
		i_start = 1'b0;
		n = 0;
		while (!link.busy && n < 600) begin
			step();
			n++;
		end
		chk("busy rose", 16'h0001, {15'h0000, link.busy});
		n = 0;
		while (link.busy && n < 1000) begin
			h = o_holding;
			step();
			n++;
		end
		chk("holding", 16'h0001, {15'h0000, h});
		chk("busy span", 16'h0001, {15'h0000, n >= CONV - 2 &&
			n <= (sleep ? CONV + WAKE + 8 : CONV + 2)});
		chk("asleep", {15'h0000, sleep}, {15'h0000, o_asleep});
		n = 0;
		while (!o_valid && n < 2000) begin
			step();
			n++;
		end
		chk("valid", 16'h0001, {15'h0000, o_valid});
		chk("result", {2'b00, smp}, {2'b00, o_result});
		chk("frame", {2'b00, smp}, frame_q);
		chk("release", {15'h0000, 1'bz}, {15'h0000, shift_data_out_pin});
		chk("tracking", 16'h0000, {15'h0000, o_holding});
		$display("test convert sleep=%0d done", sleep);
	endtask
	// ==========================================
	// Main sequence and watchdog
	initial begin
		repeat (2) @(posedge i_clk);
		#1;
		i_rstn = 1'b1;
		for (int k = 0; k < 4; k++) begin
			convert(1'b0, pat[k]);
		end
		for (int k = 0; k < 3; k++) begin
			convert(1'b1, pat[k]);
		end
		repeat (300) step(); // Wake ends first: long pulse
		convert(1'b0, 14'h2001);
		results();
	end
	initial begin
		#400000;
		n_mismatch++;
		$display("watchdog expired");
		results();
	end
endmodule
`default_nettype wire
